/* File: hdl/siplo_pkg.sv */
package siplo_pkg;

  // Shift and latch width
  localparam int unsigned STAGE_COUNT = 8;
  // Index of the serial input stage
  localparam int unsigned FIRST_STAGE = 0;
  // Index of the stage that feeds the cascade output
  localparam int unsigned LAST_STAGE = 7;
  // Flip-flops in each pin synchroniser
  localparam int unsigned SYNC_DEPTH = 2;
  // Pin inputs synchronised together: shift clock, latch clock, data, clear, enable
  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned PIN_SHIFT_CLK = 0;
  localparam int unsigned PIN_LATCH_CLK = 1;
  localparam int unsigned PIN_SERIAL = 2;
  localparam int unsigned PIN_CLEAR_N = 3;
  localparam int unsigned PIN_OE_N = 4;
  // Values held by the synchronisers during reset: clocks low, data low, inactive controls
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h18;
  // Reset values of the storage
  localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
  localparam logic [STAGE_COUNT-1:0] LATCH_RESET = 8'h00;
  localparam logic [STAGE_COUNT-1:0] OE_N_RESET = 8'hFF;
  localparam logic [STAGE_COUNT-1:0] ALL_ZERO = 8'h00;

endpackage : siplo_pkg

/* File: hdl/siplo_sync.sv */
`timescale 1ns/1ps
module siplo_sync #(
  parameter int unsigned WIDTH = siplo_pkg::PIN_COUNT,
  parameter logic [WIDTH-1:0] RESET_VAL = siplo_pkg::PIN_RESET
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : siplo_sync

/* File: hdl/siplo_top.sv */
`timescale 1ns/1ps
module siplo_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial side pins
  input wire logic shift_clock_in,
  input wire logic latch_clock_in,
  input wire logic serial_in,
  input wire logic shift_clear_n,
  input wire logic output_enable_n,
  // Cascade output
  output logic serial_cascade_out,
  // Parallel three-state outputs, enable low while driving
  output logic [siplo_pkg::STAGE_COUNT-1:0] parallel_out_o,
  output logic [siplo_pkg::STAGE_COUNT-1:0] parallel_out_oe_n
);

  logic [siplo_pkg::PIN_COUNT-1:0] pins_async;
  logic [siplo_pkg::PIN_COUNT-1:0] pins_sync;
  logic shift_clk_prev_r;
  logic latch_clk_prev_r;
  logic shift_edge;
  logic latch_edge;
  logic clear_active;
  logic [siplo_pkg::STAGE_COUNT-1:0] shift_stage_bits_r;
  logic [siplo_pkg::STAGE_COUNT-1:0] shift_stage_bits_nxt;
  logic [siplo_pkg::STAGE_COUNT-1:0] latch_r;
  logic [siplo_pkg::STAGE_COUNT-1:0] latch_nxt;

  // Gather pins for the synchroniser
  assign pins_async = {output_enable_n, shift_clear_n, serial_in, latch_clock_in,
                       shift_clock_in};

  siplo_sync #(
    .WIDTH(siplo_pkg::PIN_COUNT),
    .RESET_VAL(siplo_pkg::PIN_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  // Rising edge from current and previous synchronised level
  function automatic logic rise_detect(input logic now_lvl, input logic prev_lvl);
    rise_detect = now_lvl & ~prev_lvl;
  endfunction : rise_detect

  // Previous levels of the synchronised clocks
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      shift_clk_prev_r <= siplo_pkg::PIN_RESET[siplo_pkg::PIN_SHIFT_CLK];
      latch_clk_prev_r <= siplo_pkg::PIN_RESET[siplo_pkg::PIN_LATCH_CLK];
    end
    else
    begin
      shift_clk_prev_r <= pins_sync[siplo_pkg::PIN_SHIFT_CLK];
      latch_clk_prev_r <= pins_sync[siplo_pkg::PIN_LATCH_CLK];
    end
  end

  // Rising edges and clear level
  assign shift_edge = rise_detect(pins_sync[siplo_pkg::PIN_SHIFT_CLK], shift_clk_prev_r);
  assign latch_edge = rise_detect(pins_sync[siplo_pkg::PIN_LATCH_CLK], latch_clk_prev_r);
  assign clear_active = ~pins_sync[siplo_pkg::PIN_CLEAR_N];

  // Next shift stages
  always_comb
  begin
    shift_stage_bits_nxt = shift_stage_bits_r;
    if (clear_active)
    begin
      shift_stage_bits_nxt = siplo_pkg::ALL_ZERO;
    end
    else if (shift_edge)
    begin
      shift_stage_bits_nxt = {shift_stage_bits_r[siplo_pkg::LAST_STAGE-1:siplo_pkg::FIRST_STAGE],
                              pins_sync[siplo_pkg::PIN_SERIAL]};
    end
  end

  // Shift stages; last stage is the cascade output
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      shift_stage_bits_r <= siplo_pkg::STAGE_RESET;
    end
    else
    begin
      shift_stage_bits_r <= shift_stage_bits_nxt;
    end
  end

  assign serial_cascade_out = shift_stage_bits_r[siplo_pkg::LAST_STAGE];

  // Next latch value, taken from stages before this cycle's shift
  always_comb
  begin
    latch_nxt = latch_r;
    if (latch_edge)
    begin
      if (clear_active)
      begin
        latch_nxt = siplo_pkg::ALL_ZERO;
      end
      else
      begin
        latch_nxt = shift_stage_bits_r;
      end
    end
  end

  // Storage latch feeds the parallel outputs
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      latch_r <= siplo_pkg::LATCH_RESET;
    end
    else
    begin
      latch_r <= latch_nxt;
    end
  end

  assign parallel_out_o = latch_r;

  // Output enable per pin, follows the synchronised enable
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      parallel_out_oe_n <= siplo_pkg::OE_N_RESET;
    end
    else
    begin
      parallel_out_oe_n <= {siplo_pkg::STAGE_COUNT{pins_sync[siplo_pkg::PIN_OE_N]}};
    end
  end

endmodule : siplo_top

/* File: tb/siplo_monitor.sv */
`timescale 1ns/1ps
module siplo_monitor (
  // Clock and reset
  input wire logic clk_sys, reset_n,
  // Pins
  input wire logic shift_clock_in, latch_clock_in, serial_in, shift_clear_n, output_enable_n,
  // Outputs
  input wire logic serial_cascade_out,
  input wire logic [siplo_pkg::STAGE_COUNT-1:0] parallel_out_o, parallel_out_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_oe_on: assert property ($fell(output_enable_n) |-> ##3 !parallel_out_oe_n)
    else $error("oe on");
  chk_oe_off: assert property ($rose(output_enable_n) |-> ##3 &parallel_out_oe_n)
    else $error("oe off");
  chk_oe_same: assert property (!parallel_out_oe_n || &parallel_out_oe_n)
    else $error("oe split");
  chk_latch_top: assert property ($rose(latch_clock_in) && $past(shift_clear_n)
    && shift_clear_n |-> ##3 parallel_out_o[7] == $past(serial_cascade_out)) else $error("top");
  chk_latch_clr: assert property ($rose(latch_clock_in) && !$past(shift_clear_n)
    && !shift_clear_n |-> ##3 !parallel_out_o) else $error("latch clear");
  chk_out_hold: assert property ($changed(parallel_out_o)
    |-> $past(latch_clock_in, 3) && !$past(latch_clock_in, 4)) else $error("out");
  chk_casc_hold: assert property ($changed(serial_cascade_out) |-> !$past(shift_clear_n, 3)
    || $past(shift_clock_in, 3) && !$past(shift_clock_in, 4)) else $error("cascade");
  chk_clear_zero: assert property (!shift_clear_n [*4] |-> !serial_cascade_out)
    else $error("clear");
  cover property ($rose(latch_clock_in) && $rose(shift_clock_in));
  cover property ($rose(latch_clock_in) && !shift_clear_n);
  cover property ($fell(output_enable_n));
endmodule : siplo_monitor
bind siplo_top siplo_monitor siplo_monitor_inst (.*);

/* File: tb/siplo_ctrl_model.sv */
`timescale 1ns/1ps
module siplo_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Pins toward the block
  output logic shift_clock_in = 1'b0,
  output logic latch_clock_in = 1'b0,
  output logic serial_in = 1'b0
);
  // One clock pulse, each level held three cycles
  task automatic pulse(input logic sh, input logic la);
    @(posedge clk_sys);
    shift_clock_in <= sh;
    latch_clock_in <= la;
    repeat (3) @(posedge clk_sys);
    shift_clock_in <= 1'b0;
    latch_clock_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  // Eight bits most significant bit first, then a latch pulse unless clocks are tied
  task automatic send(input logic [7:0] val, input logic tied);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_sys);
      serial_in <= val[i];
      repeat (2) @(posedge clk_sys);
      pulse(1'b1, tied);
    end
    if (!tied)
      pulse(1'b0, 1'b1);
  endtask : send
endmodule : siplo_ctrl_model

/* File: tb/serial_in_latched_parallel_out_test.sv */
`timescale 1ns/1ps
module serial_in_latched_parallel_out_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic shift_clear_n = 1'b1;
  logic output_enable_n = 1'b1;
  logic shift_clock_in, latch_clock_in, serial_in, serial_cascade_out;
  logic [siplo_pkg::STAGE_COUNT-1:0] parallel_out_o, parallel_out_oe_n;
  int err_count = 0;
  int checked = 0;
  always #4 clk_sys = ~clk_sys;
  siplo_ctrl_model siplo_ctrl_model_inst (.*);
  siplo_top siplo_top_inst (.*);
  task automatic end_sim;
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic set_oe(input logic val);
    @(posedge clk_sys) output_enable_n <= val;
    repeat (4) @(negedge clk_sys);
  endtask : set_oe
  task automatic t_load;
    set_oe(1'b0);
    siplo_ctrl_model_inst.send(8'hA5, 1'b0);
    chk(parallel_out_o, 8'hA5);
    chk(parallel_out_oe_n, 8'h00);
    chk({7'h00, serial_cascade_out}, 8'h01);
    set_oe(1'b1);
    chk(parallel_out_oe_n, 8'hFF);
    set_oe(1'b0);
    chk(parallel_out_o, 8'hA5);
  endtask : t_load
  task automatic t_clear;
    @(posedge clk_sys) shift_clear_n <= 1'b0;
    repeat (5) @(negedge clk_sys);
    chk({7'h00, serial_cascade_out}, 8'h00);
    chk(parallel_out_o, 8'hA5);
    siplo_ctrl_model_inst.pulse(1'b0, 1'b1);
    chk(parallel_out_o, 8'h00);
    @(posedge clk_sys) shift_clear_n <= 1'b1;
  endtask : t_clear
  task automatic t_tied;
    siplo_ctrl_model_inst.send(8'h8F, 1'b1);
    chk(parallel_out_o, 8'h47);
    siplo_ctrl_model_inst.pulse(1'b0, 1'b1);
    chk(parallel_out_o, 8'h8F);
    chk({7'h00, serial_cascade_out}, 8'h01);
  endtask : t_tied
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_load;
    t_clear;
    t_tied;
    end_sim;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_sim;
  end
endmodule : serial_in_latched_parallel_out_test
